// *** rtl/rsud_defs.vh ***
// Operation
// - byte 5 bit 7 gates ADC reference load
// - byte 5 bits 2-1 select reference level
// - byte 5 bit 0 selects internal or supply
// - byte 6 bit 7 gates detector changes
// - bit 3 loads rising trigger when bit 4
// - bit 1 loads falling trigger when bit 2
// - bit 0 clears detection flag when enabled
// - byte 7 equal one loads pin settings
// - output pin drives byte 8 bit 4
// - byte 8 bit 3 direction, one is input
// - byte 8 bits 2-0 select pin function
// - settings volatile, reset restores defaults
// - reply echoes command, then 0x00 status
`ifndef RSUD_DEFS_VH
`define RSUD_DEFS_VH

`define RSUD_CMD_SET        8'h60
`define RSUD_RESP_OK        8'h00
`define RSUD_RESP_FILL      8'h00
`define RSUD_GP_ALTER       8'h01

`define RSUD_IDX_FIRST      6'h00
`define RSUD_IDX_STATUS     6'h01
`define RSUD_IDX_ADC        6'h05
`define RSUD_IDX_IOC        6'h06
`define RSUD_IDX_ALTER      6'h07
`define RSUD_IDX_GP0        6'h08
`define RSUD_IDX_LAST       6'h3F
`define RSUD_IDX_STEP       6'h01

`define RSUD_LOAD_BIT       7
`define RSUD_ADC_LVL_HI     2
`define RSUD_ADC_LVL_LO     1
`define RSUD_ADC_SRC_BIT    0
`define RSUD_IOC_RISE_MOD   4
`define RSUD_IOC_RISE_VAL   3
`define RSUD_IOC_FALL_MOD   2
`define RSUD_IOC_FALL_VAL   1
`define RSUD_IOC_CLR_BIT    0
`define RSUD_GP_OUT_BIT     4
`define RSUD_GP_DIR_BIT     3
`define RSUD_GP_FUNC_HI     2
`define RSUD_GP_FUNC_LO     0

`define RSUD_LVL_OFF        2'h0
`define RSUD_LVL_1024       2'h1
`define RSUD_LVL_2048       2'h2
`define RSUD_LVL_4096       2'h3
`define RSUD_SEL_NONE       3'h0
`define RSUD_SEL_1024       3'h1
`define RSUD_SEL_2048       3'h2
`define RSUD_SEL_4096       3'h4

`define RSUD_FUNC_GPIO      3'h0
`define RSUD_FUNC_SUSPEND   3'h1
`define RSUD_FUNC_RXLED     3'h2

`define RSUD_RST_LVL        2'h0
`define RSUD_RST_SRC        1'h0
`define RSUD_RST_RISE       1'h0
`define RSUD_RST_FALL       1'h0
`define RSUD_RST_FUNC       3'h0
`define RSUD_RST_DIR        1'h1
`define RSUD_RST_OUT        1'h0
`define RSUD_RST_BYTE       8'h00

`endif

// *** rtl/rsud_edge_detect.v ***
`timescale 1ns/1ps
`include "rsud_defs.vh"
module rsud_edge_detect (
  input  wire i_clk,
  input  wire i_resetn,
  input  wire i_pin,
  input  wire i_rise_en,
  input  wire i_fall_en,
  input  wire i_clear,
  output wire o_flag
);
  reg  s1_q;
  reg  s2_q;
  reg  prev_q;
  reg  flag_q;
  wire rise;
  wire fall;

  assign rise   = s2_q & ~prev_q;
  assign fall   = ~s2_q & prev_q;
  assign o_flag = flag_q;

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      prev_q <= 1'b0;
      flag_q <= 1'b0;
    end else begin
      s1_q   <= i_pin;
      s2_q   <= s1_q;
      prev_q <= s2_q;
      // a new edge in the clearing cycle keeps the flag set
      if ((rise & i_rise_en) | (fall & i_fall_en)) begin
        flag_q <= 1'b1;
      end else if (i_clear) begin
        flag_q <= 1'b0;
      end
    end
  end
endmodule

// *** rtl/rsud_top.v ***
`timescale 1ns/1ps
`include "rsud_defs.vh"
module rsud_top (
  input  wire       i_clk,
  input  wire       i_resetn,
  input  wire       i_rx_valid,
  input  wire       i_rx_first,
  input  wire [7:0] i_rx_data,
  output wire       o_rx_ready,
  output wire       o_tx_valid,
  output wire       o_tx_first,
  output wire [7:0] o_tx_data,
  input  wire       i_tx_ready,
  input  wire       i_ioc_pin,
  input  wire       i_gp0_pin,
  input  wire       i_usb_suspend,
  input  wire       i_uart_rx_led,
  output wire       o_gp0_out,
  output wire       o_gp0_oe,
  output wire       o_gp0_in,
  output wire [1:0] o_adc_vrm_level,
  output wire [2:0] o_adc_vrm_sel,
  output wire       o_adc_ref_internal,
  output wire       o_ioc_rise_en,
  output wire       o_ioc_fall_en,
  output wire       o_ioc_flag,
  output wire [2:0] o_gp0_func,
  output wire       o_gp0_dir_in,
  output wire       o_gp0_out_value,
  output wire       o_applied,
  output wire       o_ignored
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_RECV = 2'h1;
  localparam [1:0] ST_RESP = 2'h2;

  // one-hot reference level for the analog side
  function [2:0] lvl_sel;
    input [1:0] lvl;
    begin
      case (lvl)
        `RSUD_LVL_1024: lvl_sel = `RSUD_SEL_1024;
        `RSUD_LVL_2048: lvl_sel = `RSUD_SEL_2048;
        `RSUD_LVL_4096: lvl_sel = `RSUD_SEL_4096;
        default:        lvl_sel = `RSUD_SEL_NONE;
      endcase
    end
  endfunction

  // only the three documented pin functions are accepted
  function func_ok;
    input [2:0] f;
    begin
      case (f)
        `RSUD_FUNC_GPIO:    func_ok = 1'b1;
        `RSUD_FUNC_SUSPEND: func_ok = 1'b1;
        `RSUD_FUNC_RXLED:   func_ok = 1'b1;
        default:            func_ok = 1'b0;
      endcase
    end
  endfunction

  reg  [1:0] state_q;
  reg  [1:0] state_d;
  reg  [5:0] idx_q;
  reg  [5:0] idx_d;
  reg        match_q;
  reg        match_d;
  reg  [7:0] cmd_q;
  reg  [7:0] cmd_d;
  reg  [7:0] adc_b_q;
  reg  [7:0] ioc_b_q;
  reg  [7:0] alter_b_q;
  reg  [7:0] gp0_b_q;
  reg        rx_ready_q;
  reg        tx_valid_q;
  reg        tx_first_q;
  reg  [7:0] tx_data_q;
  reg  [5:0] tx_idx_q;
  reg  [1:0] lvl_q;
  reg  [2:0] sel_q;
  reg        src_q;
  reg        rise_q;
  reg        fall_q;
  reg        clr_q;
  reg  [2:0] func_q;
  reg        dir_q;
  reg        outv_q;
  reg        gp_s1_q;
  reg        gp_s2_q;
  reg        gp_in_q;
  reg        pin_out_q;
  reg        pin_oe_q;
  reg        applied_q;
  reg        ignored_q;
  wire       rx_take;
  wire [5:0] cur_idx;
  wire       rx_done;
  wire       do_apply;
  wire       tx_take;
  wire       ioc_flag;
  wire [2:0] new_func;

  assign rx_take  = i_rx_valid & rx_ready_q;
  assign cur_idx  = i_rx_first ? `RSUD_IDX_FIRST : idx_q;
  assign rx_done  = rx_take & (state_q == ST_RECV) & ~i_rx_first & (idx_q == `RSUD_IDX_LAST);
  assign do_apply = rx_done & match_q;
  assign tx_take  = tx_valid_q & i_tx_ready;
  assign new_func = gp0_b_q[`RSUD_GP_FUNC_HI:`RSUD_GP_FUNC_LO];

  // report framing: byte 0 is marked by i_rx_first, report is 64 bytes
  always @* begin
    state_d = state_q;
    idx_d   = idx_q;
    match_d = match_q;
    cmd_d   = cmd_q;
    case (state_q)
      ST_IDLE: begin
        if (rx_take & i_rx_first) begin
          state_d = ST_RECV;
          idx_d   = `RSUD_IDX_STEP;
          cmd_d   = i_rx_data;
          match_d = (i_rx_data == `RSUD_CMD_SET);
        end
      end
      ST_RECV: begin
        if (rx_take) begin
          idx_d = cur_idx + `RSUD_IDX_STEP;
          if (i_rx_first) begin
            cmd_d   = i_rx_data;
            match_d = (i_rx_data == `RSUD_CMD_SET);
          end else if (rx_done) begin
            idx_d   = `RSUD_IDX_FIRST;
            state_d = match_q ? ST_RESP : ST_IDLE;
          end
        end
      end
      ST_RESP: begin
        if (tx_take & (tx_idx_q == `RSUD_IDX_LAST)) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        idx_d   = `RSUD_IDX_FIRST;
      end
    endcase
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q    <= ST_IDLE;
      idx_q      <= `RSUD_IDX_FIRST;
      match_q    <= 1'b0;
      cmd_q      <= `RSUD_RST_BYTE;
      rx_ready_q <= 1'b0;
      adc_b_q    <= `RSUD_RST_BYTE;
      ioc_b_q    <= `RSUD_RST_BYTE;
      alter_b_q  <= `RSUD_RST_BYTE;
      gp0_b_q    <= `RSUD_RST_BYTE;
    end else begin
      state_q    <= state_d;
      idx_q      <= idx_d;
      match_q    <= match_d;
      cmd_q      <= cmd_d;
      rx_ready_q <= (state_d != ST_RESP);
      if (rx_take & (state_q == ST_RECV) & ~i_rx_first) begin
        case (idx_q)
          `RSUD_IDX_ADC:   adc_b_q   <= i_rx_data;
          `RSUD_IDX_IOC:   ioc_b_q   <= i_rx_data;
          `RSUD_IDX_ALTER: alter_b_q <= i_rx_data;
          `RSUD_IDX_GP0:   gp0_b_q   <= i_rx_data;
          default: begin
          end
        endcase
      end
    end
  end

  // settings are applied together once the whole report has arrived;
  // reset brings back the fixed defaults, nothing here is kept across it
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lvl_q     <= `RSUD_RST_LVL;
      sel_q     <= `RSUD_SEL_NONE;
      src_q     <= `RSUD_RST_SRC;
      rise_q    <= `RSUD_RST_RISE;
      fall_q    <= `RSUD_RST_FALL;
      clr_q     <= 1'b0;
      func_q    <= `RSUD_RST_FUNC;
      dir_q     <= `RSUD_RST_DIR;
      outv_q    <= `RSUD_RST_OUT;
      applied_q <= 1'b0;
      ignored_q <= 1'b0;
    end else begin
      clr_q     <= 1'b0;
      applied_q <= do_apply;
      ignored_q <= rx_done & ~match_q;
      if (do_apply) begin
        // bits 6-3 of the reference byte are never looked at
        if (adc_b_q[`RSUD_LOAD_BIT]) begin
          lvl_q <= adc_b_q[`RSUD_ADC_LVL_HI:`RSUD_ADC_LVL_LO];
          sel_q <= lvl_sel(adc_b_q[`RSUD_ADC_LVL_HI:`RSUD_ADC_LVL_LO]);
          src_q <= adc_b_q[`RSUD_ADC_SRC_BIT];
        end
        if (ioc_b_q[`RSUD_LOAD_BIT]) begin
          if (ioc_b_q[`RSUD_IOC_RISE_MOD]) begin
            rise_q <= ioc_b_q[`RSUD_IOC_RISE_VAL];
          end
          if (ioc_b_q[`RSUD_IOC_FALL_MOD]) begin
            fall_q <= ioc_b_q[`RSUD_IOC_FALL_VAL];
          end
          clr_q <= ioc_b_q[`RSUD_IOC_CLR_BIT];
        end
        if (alter_b_q == `RSUD_GP_ALTER) begin
          outv_q <= gp0_b_q[`RSUD_GP_OUT_BIT];
          dir_q  <= gp0_b_q[`RSUD_GP_DIR_BIT];
          // unlisted function codes leave the designation alone
          if (func_ok(new_func)) begin
            func_q <= new_func;
          end
        end
      end
    end
  end

  rsud_edge_detect u_edge (
    .i_clk     (i_clk),
    .i_resetn  (i_resetn),
    .i_pin     (i_ioc_pin),
    .i_rise_en (rise_q),
    .i_fall_en (fall_q),
    .i_clear   (clr_q),
    .o_flag    (ioc_flag)
  );

  // pin mux for the first general pin, registered toward the pad
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gp_s1_q   <= 1'b0;
      gp_s2_q   <= 1'b0;
      gp_in_q   <= 1'b0;
      pin_out_q <= 1'b0;
      pin_oe_q  <= 1'b0;
    end else begin
      gp_s1_q <= i_gp0_pin;
      gp_s2_q <= gp_s1_q;
      gp_in_q <= gp_s2_q;
      case (func_q)
        `RSUD_FUNC_GPIO: begin
          pin_out_q <= outv_q;
          pin_oe_q  <= ~dir_q;
        end
        `RSUD_FUNC_SUSPEND: begin
          pin_out_q <= i_usb_suspend;
          pin_oe_q  <= 1'b1;
        end
        `RSUD_FUNC_RXLED: begin
          pin_out_q <= i_uart_rx_led;
          pin_oe_q  <= 1'b1;
        end
        default: begin
          pin_out_q <= 1'b0;
          pin_oe_q  <= 1'b0;
        end
      endcase
    end
  end

  // 64-byte reply: echoed code, success status, zero fill
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_valid_q <= 1'b0;
      tx_first_q <= 1'b0;
      tx_data_q  <= `RSUD_RST_BYTE;
      tx_idx_q   <= `RSUD_IDX_FIRST;
    end else if (do_apply) begin
      tx_valid_q <= 1'b1;
      tx_first_q <= 1'b1;
      tx_data_q  <= cmd_q;
      tx_idx_q   <= `RSUD_IDX_FIRST;
    end else if (tx_take) begin
      tx_first_q <= 1'b0;
      if (tx_idx_q == `RSUD_IDX_LAST) begin
        tx_valid_q <= 1'b0;
        tx_data_q  <= `RSUD_RST_BYTE;
        tx_idx_q   <= `RSUD_IDX_FIRST;
      end else begin
        tx_idx_q <= tx_idx_q + `RSUD_IDX_STEP;
        if (tx_idx_q == `RSUD_IDX_FIRST) begin
          tx_data_q <= `RSUD_RESP_OK;
        end else begin
          tx_data_q <= `RSUD_RESP_FILL;
        end
      end
    end
  end

  assign o_rx_ready         = rx_ready_q;
  assign o_tx_valid         = tx_valid_q;
  assign o_tx_first         = tx_first_q;
  assign o_tx_data          = tx_data_q;
  assign o_gp0_out          = pin_out_q;
  assign o_gp0_oe           = pin_oe_q;
  assign o_gp0_in           = gp_in_q;
  assign o_adc_vrm_level    = lvl_q;
  assign o_adc_vrm_sel      = sel_q;
  assign o_adc_ref_internal = src_q;
  assign o_ioc_rise_en      = rise_q;
  assign o_ioc_fall_en      = fall_q;
  assign o_ioc_flag         = ioc_flag;
  assign o_gp0_func         = func_q;
  assign o_gp0_dir_in       = dir_q;
  assign o_gp0_out_value    = outv_q;
  assign o_applied          = applied_q;
  assign o_ignored          = ignored_q;
endmodule

// *** dv/rsud_monitor.sv ***
`timescale 1ns/1ps
module rsud_monitor (
  input wire       i_clk,
  input wire       i_resetn,
  input wire       i_tx_ready,
  input wire       i_ioc_pin,
  input wire       o_rx_ready,
  input wire       o_tx_valid,
  input wire       o_tx_first,
  input wire [7:0] o_tx_data,
  input wire       o_gp0_out,
  input wire       o_gp0_oe,
  input wire [1:0] o_adc_vrm_level,
  input wire [2:0] o_adc_vrm_sel,
  input wire       o_adc_ref_internal,
  input wire       o_ioc_rise_en,
  input wire       o_ioc_fall_en,
  input wire       o_ioc_flag,
  input wire [2:0] o_gp0_func,
  input wire       o_gp0_dir_in,
  input wire       o_gp0_out_value,
  input wire       o_applied,
  input wire       o_ignored
);
  wire [9:0] cfg = {o_adc_vrm_level, o_adc_ref_internal, o_ioc_rise_en, o_ioc_fall_en, o_gp0_func,
                    o_gp0_dir_in, o_gp0_out_value};
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_sel_onehot: assert property (o_adc_vrm_sel == {o_adc_vrm_level == 2'h3, o_adc_vrm_level == 2'h2,
    o_adc_vrm_level == 2'h1}) else $error("reference select disagrees with level");
  a_cfg_hold: assert property ($changed(cfg) |-> o_applied)
    else $error("settings changed without an applied report");
  a_reply_start: assert property (o_applied |-> o_tx_valid && o_tx_first && o_tx_data == 8'h60)
    else $error("reply does not open with the echoed code");
  a_reply_busy: assert property (o_tx_valid |-> !o_rx_ready)
    else $error("receive open while reply pending");
  a_tx_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("reply byte dropped before it was taken");
  a_ignore_quiet: assert property (o_ignored |-> o_rx_ready && !o_tx_valid && !o_applied)
    else $error("foreign report was answered");
  a_flag_clear: assert property ($fell(o_ioc_flag) |-> $past(o_applied))
    else $error("flag fell without a clearing report");
  a_flag_rise: assert property ($rose(i_ioc_pin) && o_ioc_rise_en |-> ##[1:6] o_ioc_flag)
    else $error("rising edge did not set the flag");
  a_flag_fall: assert property ($fell(i_ioc_pin) && o_ioc_fall_en |-> ##[1:6] o_ioc_flag)
    else $error("falling edge did not set the flag");
  a_func_legal: assert property (o_gp0_func <= 3'h2)
    else $error("unlisted pin function stored");
  a_pad_gpio: assert property (o_gp0_func == 3'h0 && !o_gp0_dir_in ##1 $stable(cfg) |->
    o_gp0_oe && o_gp0_out == o_gp0_out_value) else $error("output pin does not drive stored value");
endmodule
bind rsud_top rsud_monitor u_mon (.i_clk, .i_resetn, .i_tx_ready, .i_ioc_pin, .o_rx_ready, .o_tx_valid,
  .o_tx_first, .o_tx_data, .o_gp0_out, .o_gp0_oe, .o_adc_vrm_level, .o_adc_vrm_sel, .o_adc_ref_internal,
  .o_ioc_rise_en, .o_ioc_fall_en, .o_ioc_flag, .o_gp0_func, .o_gp0_dir_in, .o_gp0_out_value, .o_applied,
  .o_ignored);

// *** dv/rsud_host_model.sv ***
`timescale 1ns/1ps
module rsud_host_model (
  input  wire        i_clk,
  input  wire        i_ready,
  input  wire        i_slow,
  output logic       o_valid,
  output logic       o_first,
  output logic [7:0] o_data,
  output logic       o_tx_ready
);
  integer seed = 46145;
  initial {o_valid, o_first, o_data, o_tx_ready} = 11'h000;
  // reply bytes are taken at random when slow, so the device must hold each one
  always @(posedge i_clk) #1 o_tx_ready <= !i_slow || ($random(seed) & 1);
  task automatic send(input [7:0] code, b5, b6, b7, b8);
    logic [7:0] b;
    for (int i = 0; i < 64; i++) begin
      b = (i == 0) ? code : (i == 5) ? b5 : (i == 6) ? b6 : (i == 7) ? b7 : (i == 8) ? b8 : $random(seed);
      if (i_slow && ($random(seed) & 1)) begin
        // idle gap: data scrambled so a stale byte cannot pass
        {o_valid, o_data} = {1'b0, ~o_data};
        @(posedge i_clk);
        #1;
      end
      {o_valid, o_first, o_data} = {1'b1, i == 0, b};
      do @(posedge i_clk); while (i_ready !== 1'b1);
      #1;
    end
    {o_valid, o_first, o_data} = {2'b00, ~o_data};
  endtask
endmodule

// *** dv/rsud_top_tb_top.sv ***
`timescale 1ns/1ps
`include "rsud_defs.vh"
module rsud_top_tb_top;
  logic        i_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic        i_ioc_pin = 1'b0;
  logic        i_gp0_pin = 1'b0;
  logic        i_usb_suspend = 1'b0;
  logic        i_uart_rx_led = 1'b0;
  logic        slow = 1'b0;
  wire         i_rx_valid, i_rx_first, i_tx_ready, o_rx_ready, o_tx_valid, o_tx_first, o_gp0_out, o_gp0_oe;
  wire         o_gp0_in, o_adc_ref_internal, o_ioc_rise_en, o_ioc_fall_en, o_ioc_flag, o_gp0_dir_in;
  wire         o_gp0_out_value, o_applied, o_ignored;
  wire [7:0]   i_rx_data, o_tx_data;
  wire [1:0]   o_adc_vrm_level;
  wire [2:0]   o_adc_vrm_sel, o_gp0_func;
  wire [12:0]  cur = {o_adc_vrm_level, o_adc_vrm_sel, o_adc_ref_internal, o_ioc_rise_en, o_ioc_fall_en,
                      o_gp0_func, o_gp0_dir_in, o_gp0_out_value};
  integer      seed = 46145;
  integer      n_mismatch = 0;
  integer      cmp_count = 0;
  integer      n_ign = 0;
  integer      e_ign = 0;
  integer      tx_idx = 0;
  logic [31:0] r;
  logic [12:0] q[$];
  logic [1:0]  e_lvl;
  logic [2:0]  e_func;
  logic        e_src, e_rise, e_fall, e_flag, e_dir, e_out;
  rsud_top uut (.i_clk, .i_resetn, .i_rx_valid, .i_rx_first, .i_rx_data, .o_rx_ready, .o_tx_valid, .o_tx_first,
    .o_tx_data, .i_tx_ready, .i_ioc_pin, .i_gp0_pin, .i_usb_suspend, .i_uart_rx_led, .o_gp0_out, .o_gp0_oe,
    .o_gp0_in, .o_adc_vrm_level, .o_adc_vrm_sel, .o_adc_ref_internal, .o_ioc_rise_en, .o_ioc_fall_en,
    .o_ioc_flag, .o_gp0_func, .o_gp0_dir_in, .o_gp0_out_value, .o_applied, .o_ignored);
  rsud_host_model host (.i_clk, .i_ready(o_rx_ready), .i_slow(slow), .o_valid(i_rx_valid), .o_first(i_rx_first),
    .o_data(i_rx_data), .o_tx_ready(i_tx_ready));
  initial forever #5 i_clk = ~i_clk;
  function automatic [12:0] evec();
    evec = {e_lvl, e_lvl == 2'h3, e_lvl == 2'h2, e_lvl == 2'h1, e_src, e_rise, e_fall, e_func, e_dir, e_out};
  endfunction
  task automatic chk(input string nm, input logic [15:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic report(input [7:0] code, b5, b6, b7, b8);
    logic oe;
    logic po;
    if (code == `RSUD_CMD_SET) begin
      if (b5[7]) {e_lvl, e_src} = {b5[2:1], b5[0]};
      if (b6[7] && b6[4]) e_rise = b6[3];
      if (b6[7] && b6[2]) e_fall = b6[1];
      if (b6[7] && b6[0]) e_flag = 1'b0;
      if (b7 == `RSUD_GP_ALTER) begin
        if (b8[2:0] < 3'h3) e_func = b8[2:0];
        {e_dir, e_out} = {b8[3], b8[4]};
      end
      q.push_back(evec());
    end else
      e_ign++;
    host.send(code, b5, b6, b7, b8);
    repeat (6) @(posedge i_clk);
    for (int k = 0; k < 500 && !(o_rx_ready === 1'b1 && o_tx_valid === 1'b0); k++) @(posedge i_clk);
    #1;
    // a reply that never finished leaves the wait loop by its limit and is caught here
    chk("reply end", {tx_idx[7:0], o_rx_ready, o_tx_valid}, 10'h002);
    oe = e_func != 3'h0 || !e_dir;
    po = oe & (e_func == 3'h1 ? i_usb_suspend : e_func == 3'h2 ? i_uart_rx_led : e_out);
    chk("settings", cur, evec());
    chk("pad", {o_gp0_oe, o_gp0_oe & o_gp0_out, o_gp0_in}, {oe, po, i_gp0_pin});
    chk("flag", o_ioc_flag, e_flag);
    i_ioc_pin = 1'b1;
    repeat (8) @(posedge i_clk);
    #1 i_ioc_pin = 1'b0;
    e_flag = e_flag | e_rise | e_fall;
    repeat (8) @(posedge i_clk);
    #1 chk("edge flag", o_ioc_flag, e_flag);
  endtask
  always @(posedge i_clk) begin
    if (o_applied === 1'b1) chk("applied", cur, q.size() ? q.pop_front() : 13'h1FFF);
    if (o_ignored === 1'b1) n_ign++;
    if (o_tx_valid === 1'b1 && i_tx_ready === 1'b1) begin
      chk("reply", {o_tx_first, o_tx_data}, {tx_idx == 0, tx_idx ? `RSUD_RESP_OK : `RSUD_CMD_SET});
      tx_idx = (tx_idx + 1) % 64;
    end
  end
  initial begin
    #400000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {e_lvl, e_src, e_rise, e_fall, e_flag, e_func, e_dir, e_out} = 11'h002;
    repeat (5) @(posedge i_clk);
    #1 i_resetn = 1'b1;
    for (int t = 0; t < 24; t++) begin
      slow = t[0];
      {i_gp0_pin, i_usb_suspend, i_uart_rx_led} = $random(seed);
      r = $random(seed);
      report(t % 7 == 5 ? 8'h61 : `RSUD_CMD_SET, r[7:0], r[15:8], t % 3 ? 8'h01 : r[17:16], r[31:24]);
      $display("test %0d done", t);
      if (t == 12) begin
        // reset in mid-run must return every setting to its default
        i_resetn = 1'b0;
        {e_lvl, e_src, e_rise, e_fall, e_flag, e_func, e_dir, e_out} = 11'h002;
        tx_idx = 0;
        repeat (2) @(posedge i_clk);
        #1 chk("reset", {cur, o_ioc_flag, o_rx_ready, o_tx_valid}, {evec(), 3'b000});
        i_resetn = 1'b1;
      end
    end
    chk("ignored", n_ign, e_ign);
    print_verdict();
  end
endmodule
